//--- src/sws_core.sv
// Execution core for 16-bit stores and 8-bit subtracts, one bus cycle
// per clock. Assumes memory answers a read within the cycle it is asked.
//
// Behaviour
// - Stack-pointer store: 9F direct 4, BF extended 5, AF X 5, 18 AF Y 6.
// - Stack-pointer store writes high byte at address, low at address+1.
// - X store writes high byte at address, low at address+1; X unchanged.
// - X store: DF, FF, EF, CD EF; cycles 4, 5, 5, 6.
// - Y store writes high byte at address, low at address+1; Y unchanged.
// - Fetches read; indexed modes read FFFF once; data cycles write.
// - Stores set N from bit 15, Z on zero word, clear V.
// - Subtract memory byte from chosen accumulator; N and Z from result.
// - Carry is borrow: ~X7&M7 | M7&R7 | R7&~X7.
// - Overflow: X7&~M7&~R7 | ~X7&M7&R7, else cleared.
// - Subtract opcodes and cycle counts per mode, all cycles read.
`timescale 1ns/100ps
`default_nettype none
module sws_core (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        RUN,
    input  wire logic [7:0]  DATA_IN,
    input  wire logic        REG_WR,
    input  wire logic [2:0]  REG_SEL,
    input  wire logic [15:0] REG_WDATA,
    output logic      [15:0] ADDR,
    output logic      [7:0]  DATA_OUT,
    output logic             RW,
    output logic             INSTR_DONE,
    output logic             ILLEGAL,
    output logic      [7:0]  ACC_A,
    output logic      [7:0]  ACC_B,
    output logic      [15:0] SP,
    output logic      [15:0] IX,
    output logic      [15:0] IY,
    output logic      [7:0]  CONDITION_CODE_REGISTER,
    output logic      [15:0] PC
);
    sws_dec_if dec ();

    sws_pkg::sws_state_t state_q, state_d;
    sws_pkg::sws_kind_t  kind_q, kind_d;
    sws_pkg::sws_mode_t  mode_q, mode_d;
    logic        idxy_q, idxy_d;
    logic [7:0]  page_q, page_d;
    logic [7:0]  hi_q, hi_d;
    logic [15:0] ea_q, ea_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  dout_q, dout_d;
    logic        rw_q, rw_d;
    logic        done_q, done_d;
    logic        ill_q, ill_d;
    logic [7:0]  acc_a_q, acc_a_d;
    logic [7:0]  acc_b_q, acc_b_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] ix_q, ix_d;
    logic [15:0] iy_q, iy_d;
    logic [7:0]  ccr_q, ccr_d;
    logic [15:0] st_val;
    logic [7:0]  sub_x;
    logic [7:0]  sub_r;
    logic        sub_go;
    logic        go_data;
    logic        next_ins;
    logic        is_prefix;
    logic        ovf_ref;

    sws_decode u_decode (
        .d (dec)
    );

    // Decoder sees the live bus byte; the prefix only counts after one
    assign dec.page   = (state_q == sws_pkg::ST_PAGE) ? page_q
                                                      : sws_pkg::PAGE_NONE;
    assign dec.opcode = DATA_IN;
    assign is_prefix  = (DATA_IN == sws_pkg::PRE_Y)
                        || (DATA_IN == sws_pkg::PRE_YX)
                        || (DATA_IN == sws_pkg::PRE_XY);

    // Operand selection for the data cycles
    // stored index word
    assign st_val  = (kind_q == sws_pkg::K_ST_SP) ? sp_q
                   : (kind_q == sws_pkg::K_ST_X)  ? ix_q : iy_q;
    assign sub_x   = (kind_q == sws_pkg::K_SUB_B) ? acc_b_q : acc_a_q;
    assign sub_r   = sub_x - DATA_IN;
    assign ovf_ref = sub_x[7] ^ DATA_IN[7] ? (sub_r[7] ^ sub_x[7]) : 1'b0;

    // Sequencer: each state is the bus cycle now on the pins
    always_comb
    begin
        state_d  = state_q;
        kind_d   = kind_q;
        mode_d   = mode_q;
        idxy_d   = idxy_q;
        page_d   = page_q;
        hi_d     = hi_q;
        ea_d     = ea_q;
        pc_d     = pc_q;
        addr_d   = addr_q;
        dout_d   = dout_q;
        rw_d     = 1'b1;
        done_d   = 1'b0;
        ill_d    = 1'b0;
        acc_a_d  = acc_a_q;
        acc_b_d  = acc_b_q;
        sp_d     = sp_q;
        ix_d     = ix_q;
        iy_d     = iy_q;
        ccr_d    = ccr_q;
        sub_go   = 1'b0;
        go_data  = 1'b0;
        next_ins = 1'b0;
        case (state_q)
            sws_pkg::ST_IDLE:
            begin
                // Registers are loadable only while stopped
                if (REG_WR)
                begin
                    case (REG_SEL)
                        sws_pkg::R_A:   acc_a_d = REG_WDATA[7:0];
                        sws_pkg::R_B:   acc_b_d = REG_WDATA[7:0];
                        sws_pkg::R_SP:  sp_d    = REG_WDATA;
                        sws_pkg::R_IX:  ix_d    = REG_WDATA;
                        sws_pkg::R_IY:  iy_d    = REG_WDATA;
                        sws_pkg::R_CCR: ccr_d   = REG_WDATA[7:0];
                        sws_pkg::R_PC:  pc_d    = REG_WDATA;
                        default:        pc_d    = pc_q;
                    endcase
                end
                addr_d = pc_d;
                if (RUN)
                    state_d = sws_pkg::ST_FETCH;
            end
            sws_pkg::ST_FETCH, sws_pkg::ST_PAGE:
            begin
                pc_d   = pc_q + sws_pkg::WORD_STEP;
                addr_d = pc_d;
                if (state_q == sws_pkg::ST_FETCH && is_prefix)
                begin
                    page_d  = DATA_IN;
                    state_d = sws_pkg::ST_PAGE;
                end
                else if (!dec.valid)
                begin
                    // Unknown opcode: flag it and skip the byte
                    ill_d    = 1'b1;
                    next_ins = 1'b1;
                end
                else
                begin
                    kind_d  = dec.kind;
                    mode_d  = dec.mode;
                    idxy_d  = dec.idx_y;
                    state_d = sws_pkg::ST_OPND1;
                end
            end
            sws_pkg::ST_OPND1:
            begin
                pc_d   = pc_q + sws_pkg::WORD_STEP;
                addr_d = pc_d;
                case (mode_q)
                    sws_pkg::M_IMM:
                    begin
                        sub_go   = 1'b1;
                        next_ins = 1'b1;
                    end
                    sws_pkg::M_DIR:
                    begin
                        ea_d    = {sws_pkg::ZERO_PAGE, DATA_IN};
                        go_data = 1'b1;
                    end
                    sws_pkg::M_EXT:
                    begin
                        hi_d    = DATA_IN;
                        state_d = sws_pkg::ST_OPND2;
                    end
                    default:
                    begin
                        ea_d    = (idxy_q ? iy_q : ix_q)
                                  + {sws_pkg::ZERO_PAGE, DATA_IN};
                        addr_d  = sws_pkg::DUMMY_ADDR;
                        state_d = sws_pkg::ST_DUMMY;
                    end
                endcase
            end
            sws_pkg::ST_OPND2:
            begin
                pc_d    = pc_q + sws_pkg::WORD_STEP;
                ea_d    = {hi_q, DATA_IN};
                go_data = 1'b1;
            end
            sws_pkg::ST_DUMMY: go_data = 1'b1;
            sws_pkg::ST_READ:
            begin
                sub_go   = 1'b1;
                next_ins = 1'b1;
            end
            sws_pkg::ST_WR_HI:
            begin
                addr_d  = ea_q + sws_pkg::WORD_STEP;
                dout_d  = st_val[7:0];
                rw_d    = 1'b0;
                state_d = sws_pkg::ST_WR_LO;
            end
            sws_pkg::ST_WR_LO:
            begin
                ccr_d[sws_pkg::CCR_N] = st_val[15];
                ccr_d[sws_pkg::CCR_Z] = (st_val == sws_pkg::RESET_WORD);
                ccr_d[sws_pkg::CCR_V] = 1'b0;
                next_ins = 1'b1;
            end
            default: state_d = sws_pkg::ST_IDLE;
        endcase
        // data cycle: subtract reads, stores write high byte first
        if (go_data)
        begin
            addr_d = ea_d;
            if (kind_q == sws_pkg::K_SUB_A || kind_q == sws_pkg::K_SUB_B)
                state_d = sws_pkg::ST_READ;
            else
            begin
                dout_d  = st_val[15:8];
                rw_d    = 1'b0;
                state_d = sws_pkg::ST_WR_HI;
            end
        end
        if (sub_go)
        begin
            if (kind_q == sws_pkg::K_SUB_B)
                acc_b_d = sub_r;
            else
                acc_a_d = sub_r;
            ccr_d[sws_pkg::CCR_N] = sub_r[7];
            ccr_d[sws_pkg::CCR_Z] = (sub_r == sws_pkg::RESET_BYTE);
            ccr_d[sws_pkg::CCR_V] = (sub_x[7] & ~DATA_IN[7] & ~sub_r[7])
                                  | (~sub_x[7] & DATA_IN[7] & sub_r[7]);
            ccr_d[sws_pkg::CCR_C] = (~sub_x[7] & DATA_IN[7])
                                  | (DATA_IN[7] & sub_r[7])
                                  | (sub_r[7] & ~sub_x[7]);
        end
        // Instruction boundary: stop here if RUN has dropped
        if (next_ins)
        begin
            state_d = RUN ? sws_pkg::ST_FETCH : sws_pkg::ST_IDLE;
            addr_d  = pc_d;
            page_d  = sws_pkg::PAGE_NONE;
            done_d  = !ill_d;
        end
    end

    // State and bus registers; bus pins come straight from flip-flops
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_q <= sws_pkg::ST_IDLE;
            kind_q  <= sws_pkg::K_NONE;
            mode_q  <= sws_pkg::M_IMM;
            idxy_q  <= 1'b0;
            page_q  <= sws_pkg::PAGE_NONE;
            hi_q    <= sws_pkg::RESET_BYTE;
            ea_q    <= sws_pkg::RESET_WORD;
            pc_q    <= sws_pkg::RESET_PC;
            addr_q  <= sws_pkg::RESET_PC;
            dout_q  <= sws_pkg::RESET_BYTE;
            rw_q    <= 1'b1;
            done_q  <= 1'b0;
            ill_q   <= 1'b0;
            acc_a_q <= sws_pkg::RESET_BYTE;
            acc_b_q <= sws_pkg::RESET_BYTE;
            sp_q    <= sws_pkg::RESET_WORD;
            ix_q    <= sws_pkg::RESET_WORD;
            iy_q    <= sws_pkg::RESET_WORD;
            ccr_q   <= sws_pkg::RESET_CCR;
        end
        else
        begin
            state_q <= state_d;
            kind_q  <= kind_d;
            mode_q  <= mode_d;
            idxy_q  <= idxy_d;
            page_q  <= page_d;
            hi_q    <= hi_d;
            ea_q    <= ea_d;
            pc_q    <= pc_d;
            addr_q  <= addr_d;
            dout_q  <= dout_d;
            rw_q    <= rw_d;
            done_q  <= done_d;
            ill_q   <= ill_d;
            acc_a_q <= acc_a_d;
            acc_b_q <= acc_b_d;
            sp_q    <= sp_d;
            ix_q    <= ix_d;
            iy_q    <= iy_d;
            ccr_q   <= ccr_d;
        end
    end

    // Outputs
    assign ADDR       = addr_q;
    assign DATA_OUT   = dout_q;
    assign RW         = rw_q;
    assign INSTR_DONE = done_q;
    assign ILLEGAL    = ill_q;
    assign ACC_A      = acc_a_q;
    assign ACC_B      = acc_b_q;
    assign SP         = sp_q;
    assign IX         = ix_q;
    assign IY         = iy_q;
    assign CONDITION_CODE_REGISTER        = ccr_q;
    assign PC         = pc_q;

    // Checks on the sequencer
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    sequence sts_y_s;
        (state_q == sws_pkg::ST_FETCH && DATA_IN == sws_pkg::PRE_Y)
        ##1 (DATA_IN == sws_pkg::OP_STS_IDX);
    endsequence
    sequence wr_pair_s;
        (state_q == sws_pkg::ST_WR_HI && !RW)
        ##1 (state_q == sws_pkg::ST_WR_LO && !RW);
    endsequence

    sts_y_len_a: assert property (sts_y_s |-> ##4 state_q == sws_pkg::ST_WR_LO ##1 state_q inside {sws_pkg::ST_FETCH, sws_pkg::ST_IDLE}) else $error("stack store Y length wrong");
    sts_pair_a: assert property ((state_q == sws_pkg::ST_WR_HI && kind_q == sws_pkg::K_ST_SP) |-> DATA_OUT == sp_q[15:8] ##1 (DATA_OUT == sp_q[7:0] && ADDR == $past(ADDR) + 16'h0001)) else $error("stack store bytes wrong");
    stx_keep_a: assert property ((state_q == sws_pkg::ST_WR_HI && kind_q == sws_pkg::K_ST_X) |-> wr_pair_s and (DATA_OUT == ix_q[15:8] ##1 DATA_OUT == ix_q[7:0] ##1 ix_q == $past(ix_q, 2))) else $error("X store wrong");
    stx_ext_a: assert property ((state_q == sws_pkg::ST_FETCH && DATA_IN == sws_pkg::OP_STX_EXT) |-> RW [*3] ##1 (state_q == sws_pkg::ST_WR_HI) ##1 (state_q == sws_pkg::ST_WR_LO)) else $error("X store extended timing wrong");
    sty_keep_a: assert property ((state_q == sws_pkg::ST_WR_HI && kind_q == sws_pkg::K_ST_Y) |-> wr_pair_s and (DATA_OUT == iy_q[15:8] ##1 DATA_OUT == iy_q[7:0] ##1 iy_q == $past(iy_q, 2))) else $error("Y store wrong");
    dummy_read_a: assert property ((state_q == sws_pkg::ST_DUMMY) |-> ADDR == sws_pkg::DUMMY_ADDR && RW) else $error("dummy cycle wrong");
    write_only_a: assert property (!RW |-> state_q inside {sws_pkg::ST_WR_HI, sws_pkg::ST_WR_LO}) else $error("write outside data cycle");
    sty_code_a: assert property ((state_q == sws_pkg::ST_PAGE && page_q == sws_pkg::PRE_Y && DATA_IN == sws_pkg::OP_STX_DIR) |=> kind_q == sws_pkg::K_ST_Y && state_q == sws_pkg::ST_OPND1) else $error("Y store decode wrong");
    st_flags_a: assert property ((state_q == sws_pkg::ST_WR_LO) |=>
        ccr_q[sws_pkg::CCR_N] == $past(sp_q[15] & (kind_q == sws_pkg::K_ST_SP)
            | ix_q[15] & (kind_q == sws_pkg::K_ST_X)
            | iy_q[15] & (kind_q == sws_pkg::K_ST_Y))
        && ccr_q[sws_pkg::CCR_Z] == $past((kind_q == sws_pkg::K_ST_SP)
            ? (sp_q == 16'h0000) : (kind_q == sws_pkg::K_ST_X)
            ? (ix_q == 16'h0000) : (iy_q == 16'h0000))
        && !ccr_q[sws_pkg::CCR_V]
        && ccr_q[sws_pkg::CCR_C] == $past(ccr_q[sws_pkg::CCR_C]))
        else $error("store flags wrong");
    sub_result_a: assert property ((sub_go && kind_q == sws_pkg::K_SUB_A) |=> acc_a_q == 8'($past(sub_x) - $past(DATA_IN)) && ccr_q[sws_pkg::CCR_Z] == (acc_a_q == 8'h00)) else $error("subtract result wrong");
    sub_borrow_a: assert property (sub_go |=> ccr_q[sws_pkg::CCR_C] == ($past(sub_x) < $past(DATA_IN))) else $error("borrow wrong");
    sub_ovf_a: assert property (sub_go |=> ccr_q[sws_pkg::CCR_V] == $past(ovf_ref)) else $error("overflow wrong");
    sub_imm_a: assert property ((state_q == sws_pkg::ST_FETCH && DATA_IN == sws_pkg::OP_SUBTRACT_FROM_ACC_A_IMM) |-> RW ##1 (state_q == sws_pkg::ST_OPND1 && RW) ##1 (INSTR_DONE && RW)) else $error("subtract immediate timing wrong");
endmodule
`default_nettype wire

//--- src/sws_dec_if.sv
// Carrier between the execution core and its opcode decoder.
// Assumes the core drives page and opcode, the decoder answers at once.
`timescale 1ns/100ps
`default_nettype none
interface sws_dec_if;
    logic [7:0]         page;
    logic [7:0]         opcode;
    logic               valid;
    sws_pkg::sws_kind_t kind;
    sws_pkg::sws_mode_t mode;
    logic               idx_y;

    modport dec  (input page, opcode, output valid, kind, mode, idx_y);
    modport core (output page, opcode, input valid, kind, mode, idx_y);
endinterface
`default_nettype wire

//--- src/sws_decode.sv
// Combinational opcode decoder for the store-word and subtract groups.
// Assumes page holds the prefix byte seen before the opcode, or none.
`timescale 1ns/100ps
`default_nettype none
module sws_decode (
    sws_dec_if.dec d
);
    sws_pkg::sws_kind_t base_kind;
    sws_pkg::sws_mode_t base_mode;

    // Group and addressing mode from the opcode alone
    always_comb
    begin
        case (d.opcode)
            sws_pkg::OP_SUBTRACT_FROM_ACC_A_IMM, sws_pkg::OP_SUBTRACT_FROM_ACC_A_DIR,
            sws_pkg::OP_SUBTRACT_FROM_ACC_A_EXT, sws_pkg::OP_SUBTRACT_FROM_ACC_A_IDX: base_kind = sws_pkg::K_SUB_A;
            sws_pkg::OP_SUBTRACT_FROM_ACC_B_IMM, sws_pkg::OP_SUBTRACT_FROM_ACC_B_DIR,
            sws_pkg::OP_SUBTRACT_FROM_ACC_B_EXT, sws_pkg::OP_SUBTRACT_FROM_ACC_B_IDX: base_kind = sws_pkg::K_SUB_B;
            sws_pkg::OP_STS_DIR, sws_pkg::OP_STS_EXT,
            sws_pkg::OP_STS_IDX: base_kind = sws_pkg::K_ST_SP;
            sws_pkg::OP_STX_DIR, sws_pkg::OP_STX_EXT,
            sws_pkg::OP_STX_IDX: base_kind = sws_pkg::K_ST_X;
            default: base_kind = sws_pkg::K_NONE;
        endcase
        case (d.opcode)
            sws_pkg::OP_SUBTRACT_FROM_ACC_A_DIR, sws_pkg::OP_SUBTRACT_FROM_ACC_B_DIR,
            sws_pkg::OP_STS_DIR, sws_pkg::OP_STX_DIR: base_mode = sws_pkg::M_DIR;
            sws_pkg::OP_SUBTRACT_FROM_ACC_A_EXT, sws_pkg::OP_SUBTRACT_FROM_ACC_B_EXT,
            sws_pkg::OP_STS_EXT, sws_pkg::OP_STX_EXT: base_mode = sws_pkg::M_EXT;
            sws_pkg::OP_SUBTRACT_FROM_ACC_A_IDX, sws_pkg::OP_SUBTRACT_FROM_ACC_B_IDX,
            sws_pkg::OP_STS_IDX, sws_pkg::OP_STX_IDX: base_mode = sws_pkg::M_IDX;
            default: base_mode = sws_pkg::M_IMM;
        endcase
    end

    // Prefix pages; the Y store lives only on prefixed pages so that it
    // never shares an encoding with the X store
    always_comb
    begin
        d.mode  = base_mode;
        d.kind  = base_kind;
        d.idx_y = 1'b0;
        d.valid = 1'b0;
        case (d.page)
            sws_pkg::PAGE_NONE: d.valid = (base_kind != sws_pkg::K_NONE);
            sws_pkg::PRE_Y:
            begin
                if (base_kind == sws_pkg::K_ST_X)
                begin
                    d.kind  = sws_pkg::K_ST_Y;
                    d.idx_y = (base_mode == sws_pkg::M_IDX);
                    d.valid = 1'b1;
                end
                else
                begin
                    d.idx_y = 1'b1;
                    d.valid = (base_mode == sws_pkg::M_IDX)
                              && (base_kind != sws_pkg::K_NONE);
                end
            end
            sws_pkg::PRE_YX:
            begin
                d.kind  = sws_pkg::K_ST_Y;
                d.valid = (d.opcode == sws_pkg::OP_STX_IDX);
            end
            sws_pkg::PRE_XY:
            begin
                d.idx_y = 1'b1;
                d.valid = (d.opcode == sws_pkg::OP_STX_IDX);
            end
            default: d.valid = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

//--- src/sws_pkg.sv
// Shared constants and types for the store-word and subtract execution core.
// Assumes a byte-wide memory bus, one bus cycle per core clock.
package sws_pkg;

    // Opcodes, unprefixed page
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_A_IMM = 8'h80;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_A_DIR = 8'h90;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_A_EXT = 8'hB0;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_A_IDX = 8'hA0;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_B_IMM = 8'hC0;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_B_DIR = 8'hD0;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_B_EXT = 8'hF0;
    localparam logic [7:0] OP_SUBTRACT_FROM_ACC_B_IDX = 8'hE0;
    localparam logic [7:0] OP_STS_DIR  = 8'h9F;
    localparam logic [7:0] OP_STS_EXT  = 8'hBF;
    localparam logic [7:0] OP_STS_IDX  = 8'hAF;
    localparam logic [7:0] OP_STX_DIR  = 8'hDF;
    localparam logic [7:0] OP_STX_EXT  = 8'hFF;
    localparam logic [7:0] OP_STX_IDX  = 8'hEF;

    // Prefix bytes; PAGE_NONE marks an unprefixed opcode
    localparam logic [7:0] PAGE_NONE   = 8'h00;
    localparam logic [7:0] PRE_Y       = 8'h18;
    localparam logic [7:0] PRE_YX      = 8'h1A;
    localparam logic [7:0] PRE_XY      = 8'hCD;

    // Bus and reset values
    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
    localparam logic [15:0] RESET_PC   = 16'h0000;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [7:0]  RESET_CCR  = 8'hD0;
    localparam logic [7:0]  ZERO_PAGE  = 8'h00;
    localparam logic [15:0] WORD_STEP  = 16'h0001;

    // Condition code bit positions
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_FETCH = 4'h1,
        ST_PAGE  = 4'h2,
        ST_OPND1 = 4'h3,
        ST_OPND2 = 4'h4,
        ST_DUMMY = 4'h5,
        ST_READ  = 4'h6,
        ST_WR_HI = 4'h7,
        ST_WR_LO = 4'h8
    } sws_state_t;

    typedef enum logic [2:0] {
        K_NONE  = 3'h0,
        K_SUB_A = 3'h1,
        K_SUB_B = 3'h2,
        K_ST_SP = 3'h3,
        K_ST_X  = 3'h4,
        K_ST_Y  = 3'h5
    } sws_kind_t;

    typedef enum logic [1:0] {
        M_IMM = 2'h0,
        M_DIR = 2'h1,
        M_EXT = 2'h2,
        M_IDX = 2'h3
    } sws_mode_t;

    typedef enum logic [2:0] {
        R_A   = 3'h0,
        R_B   = 3'h1,
        R_SP  = 3'h2,
        R_IX  = 3'h3,
        R_IY  = 3'h4,
        R_CCR = 3'h5,
        R_PC  = 3'h6
    } sws_rsel_t;

endpackage

//--- verif/store_word_and_subtract_exec_bench.sv
// Self-checking bench for the store-word and subtract core.
// Assumes the memory model on the bus; registers preset by loads.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module store_word_and_subtract_exec_bench;
    localparam int NI = 23;
    // Lead-in subtract, then every store and subtract encoding
    localparam logic [471:0] PROG = {96'h8000DF40BF1234AF1018AF20,
        80'hCDEF3018DF5018FF2000, 96'h18EF601AEF708070C0019080,
        88'hF03000A00518E007B03000, 96'hE00518A007D080FF4000EF00, 16'h9F90};
    localparam logic [91:0] CYC = 92'h04556656662234454453554;
    localparam logic [183:0] CCRS = {88'hD0D8D0D0D0D8D4D4D4D4D9,
        96'hD2D4DBD9D8D0D2D4DBD9D9D1};
    localparam logic [383:0] WR = {128'h0040ABCD12347F10ABDD7F1000207F10,
        128'h0030ABCD005000002000000000600000,
        128'hAC3D00004000ABCDABCDABCD00907F10};
    logic CORE_CLK, RESETN, RUN, REG_WR, RW, INSTR_DONE, ILLEGAL;
    logic [2:0] REG_SEL;
    logic [7:0] DATA_IN, DATA_OUT, ACC_A, ACC_B, CONDITION_CODE_REGISTER;
    logic [15:0] REG_WDATA, ADDR, SP, IX, IY, PC;
    int fail_count = 0, num_checks = 0, cyc = 0, gap = 0, k = 0;
    int dummies = 0, writes = 0, illegals = 0;
    int gaps [NI];
    logic [7:0] ccrs [NI];

    sws_core u_sws_core (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .RUN(RUN),
        .DATA_IN(DATA_IN), .REG_WR(REG_WR), .REG_SEL(REG_SEL),
        .REG_WDATA(REG_WDATA), .ADDR(ADDR), .DATA_OUT(DATA_OUT), .RW(RW),
        .INSTR_DONE(INSTR_DONE), .ILLEGAL(ILLEGAL), .ACC_A(ACC_A),
        .ACC_B(ACC_B), .SP(SP), .IX(IX), .IY(IY), .CONDITION_CODE_REGISTER(CONDITION_CODE_REGISTER), .PC(PC));
    sws_mem_model u_sws_mem_model (.clk(CORE_CLK), .addr(ADDR), .rw(RW),
        .wdata(DATA_OUT), .rdata(DATA_IN));

    // Free-running core clock
    initial
    begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    // Gap between completions is the instruction's length in cycles
    always @(negedge CORE_CLK)
    begin
        gap++;
        if (ADDR === 16'hFFFF && RW === 1'b1)
            dummies++;
        if (RW === 1'b0)
            writes++;
        if (ILLEGAL === 1'b1)
            illegals++;
        if (INSTR_DONE === 1'b1 && k < NI)
        begin
            gaps[k] = gap;
            ccrs[k] = CONDITION_CODE_REGISTER;
            k++;
            gap = 0;
        end
    end

    // Hang guard, far above the hundred-odd cycles the run needs
    always @(posedge CORE_CLK)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic ld(input logic [2:0] s, input logic [15:0] v);
        @(posedge CORE_CLK);
        #1;
        REG_WR = 1'b1;
        REG_SEL = s;
        REG_WDATA = v;
    endtask

    task automatic t_reset();
        `CHK(ADDR, 16'h0000)
        `CHK(RW, 1'b1)
        `CHK(CONDITION_CODE_REGISTER, 8'hD0)
        `CHK(INSTR_DONE, 1'b0)
    endtask

    // Loads back to back; IDLE must then address the new PC
    task automatic t_load();
        ld(sws_pkg::R_A, 16'h0050);
        ld(sws_pkg::R_B, 16'h0080);
        ld(sws_pkg::R_SP, 16'h7F10);
        ld(sws_pkg::R_IX, 16'hABCD);
        ld(sws_pkg::R_IY, 16'h0000);
        ld(sws_pkg::R_PC, 16'h0100);
        @(posedge CORE_CLK);
        #1;
        REG_WR = 1'b0;
        `CHK(IX, 16'hABCD)
        `CHK(ADDR, 16'h0100)
    endtask

    // Whole program back to back, judged per instruction
    task automatic t_program();
        logic [15:0] a;
        int n;
        for (int i = 0; i < 59; i++)
            u_sws_mem_model.mem[16'h0100 + i] = PROG[8*(58-i) +: 8];
        u_sws_mem_model.mem[16'h0080] = 8'hE0;
        u_sws_mem_model.mem[16'h3000] = 8'h80;
        u_sws_mem_model.mem[16'hABD2] = 8'h01;
        u_sws_mem_model.mem[16'h0007] = 8'h7F;
        @(posedge CORE_CLK);
        #1;
        RUN = 1'b1;
        n = 0;
        while (k < NI && n < 500)
        begin
            @(posedge CORE_CLK);
            n++;
        end
        #1;
        RUN = 1'b0;
        `CHK(k, NI)
        for (int i = 1; i < NI; i++)
            `CHK(gaps[i], int'(CYC[4*(NI-1-i) +: 4]))
        for (int i = 0; i < NI; i++)
            `CHK(ccrs[i], CCRS[8*(NI-1-i) +: 8])
        for (int i = 0; i < 12; i++)
        begin
            a = WR[32*(11-i)+16 +: 16];
            `CHK({u_sws_mem_model.mem[a], u_sws_mem_model.mem[a+1]},
                WR[32*(11-i) +: 16])
        end
        `CHK(dummies, 10)
        `CHK(writes, 24)
        `CHK(ACC_A, 8'h00)
        `CHK(ACC_B, 8'h9F)
        `CHK(IX, 16'hABCD)
        `CHK(IY, 16'h0000)
        `CHK(SP, 16'h7F10)
        // Filler after the program is unknown code: two flags, then stop
        repeat (3) @(posedge CORE_CLK);
        #1;
        `CHK(illegals, 2)
        `CHK(PC, 16'h013D)
        `CHK(ADDR, 16'h013D)
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial
    begin
        RESETN = 1'b0;
        RUN = 1'b0;
        REG_WR = 1'b0;
        REG_SEL = 3'h0;
        REG_WDATA = 16'h0000;
        repeat (2) @(posedge CORE_CLK);
        #1;
        t_reset();
        RESETN = 1'b1;
        t_load();
        t_program();
        summarize();
    end
endmodule
`default_nettype wire

//--- verif/sws_mem_model.sv
// Byte-wide memory standing on the core's bus.
// Assumes reads are answered in the same cycle, writes land at cycle end.
`timescale 1ns/100ps
`default_nettype none
module sws_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] addr,
    input  wire logic        rw,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem [0:65535];

    // Filled with EE so that a store of zero shows up
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hEE;
    end

    // Undriven in write cycles: a moving pattern, never stale data
    assign rdata = rw ? mem[addr] : ~addr[7:0];

    // Write cycle takes the core's byte at its closing edge
    always @(posedge clk)
    begin
        if (!rw)
            mem[addr] <= wdata;
    end
endmodule
`default_nettype wire
